// *** logic/sspr_regs.v ***
/*
 * Register slice: sticky lock-loss flag with clear, phase shift
 * controls for dividers C and D, oscillator driver select, revision
 * byte, two pin function registers, interrupt status and mask.
 * Assumes a single-cycle strobe master on mclk and synchronous pins.
 */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "sspr_defs.vh"

module sspr_regs (
    mclk,
    reset,
    ce,
    addr,
    wr_data,
    wr_en,
    rd_en,
    rd_data,
    synth_unlocked,
    status_table,
    pin_in,
    lock_loss_sticky,
    period_shift_c,
    eighth_turn_shift_c,
    eighth_turn_steps_c,
    period_shift_d,
    eighth_turn_shift_d,
    eighth_turn_steps_d,
    osc_out_driver_en,
    ctrl_table,
    ctrl_pin_mask,
    pin_out,
    pin_oe,
    irq
);
    input  wire         mclk;
    input  wire         reset;
    input  wire         ce;
    input  wire [7:0]   addr;
    input  wire [7:0]   wr_data;
    input  wire         wr_en;
    input  wire         rd_en;
    output reg  [7:0]   rd_data;
    input  wire         synth_unlocked;
    input  wire [127:0] status_table;
    input  wire [1:0]   pin_in;
    output reg          lock_loss_sticky;
    output reg  [12:0]  period_shift_c;
    output reg  [2:0]   eighth_turn_shift_c;
    output reg  [3:0]   eighth_turn_steps_c;
    output reg  [12:0]  period_shift_d;
    output reg  [2:0]   eighth_turn_shift_d;
    output reg  [3:0]   eighth_turn_steps_d;
    output reg          osc_out_driver_en;
    output reg  [127:0] ctrl_table;
    output reg  [127:0] ctrl_pin_mask;
    output reg  [1:0]   pin_out;
    output reg  [1:0]   pin_oe;
    output reg          irq;

    // ====================================================
    // Storage
    reg         lock_loss_clear_reg;
    reg [15:0]  phase_c_reg;
    reg [15:0]  phase_d_reg;
    reg         osc_disable_reg;
    reg [7:0]   pin0_func_reg;
    reg [7:0]   pin1_func_reg;
    reg [1:0]   irq_status_reg;
    reg [1:0]   irq_mask_reg;

    reg         lock_loss_next;
    reg [1:0]   irq_status_next;
    reg [7:0]   rd_data_next;
    reg         mapped;
    reg [127:0] ctrl_table_next;
    reg [127:0] ctrl_mask_next;
    reg [1:0]   pin_out_next;
    reg [1:0]   pin_oe_next;
    reg [7:0]   func;
    integer     p;

    // ====================================================
    // Eighth-turn decode, signed steps of 45 degrees
    function [3:0] turn_steps;
        input [2:0] code;
        begin
            case (code)
                3'h0: turn_steps = 4'h0;
                3'h1: turn_steps = 4'hF;
                3'h2: turn_steps = 4'hE;
                3'h3: turn_steps = 4'hD;
                3'h4: turn_steps = 4'h4;
                3'h5: turn_steps = 4'h3;
                3'h6: turn_steps = 4'h2;
                3'h7: turn_steps = 4'h1;
                default: turn_steps = 4'h0;
            endcase
        end
    endfunction

    // ====================================================
    // Address decode and read mux
    always @* begin
        mapped = 1'b1;
        rd_data_next = 8'h00;
        case (addr)
            `SSPR_LOCK_STATUS_ADDR: begin
                rd_data_next = {7'h00, lock_loss_sticky}; // RULE1
            end
            `SSPR_LOCK_CLEAR_ADDR: begin
                rd_data_next = {7'h00, lock_loss_clear_reg};
            end
            `SSPR_PHASE_C_LO_ADDR: begin
                rd_data_next = phase_c_reg[7:0];
            end
            `SSPR_PHASE_C_HI_ADDR: begin
                rd_data_next = phase_c_reg[15:8];
            end
            `SSPR_PHASE_D_LO_ADDR: begin
                rd_data_next = phase_d_reg[7:0];
            end
            `SSPR_PHASE_D_HI_ADDR: begin
                rd_data_next = phase_d_reg[15:8];
            end
            `SSPR_OSC_CTRL_ADDR: begin
                rd_data_next = {7'h00, osc_disable_reg};
            end
            `SSPR_REVISION_ADDR: begin
                rd_data_next = `SSPR_REVISION_VALUE; // RULE11
            end
            `SSPR_PIN0_FUNC_ADDR: begin
                rd_data_next = pin0_func_reg;
            end
            `SSPR_PIN1_FUNC_ADDR: begin
                rd_data_next = pin1_func_reg;
            end
            `SSPR_IRQ_STATUS_ADDR: begin
                rd_data_next = {6'h00, irq_status_reg};
            end
            `SSPR_IRQ_MASK_ADDR: begin
                rd_data_next = {6'h00, irq_mask_reg};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ====================================================
    // Sticky flags; a set always beats a clear
    always @* begin
        lock_loss_next = synth_unlocked // RULE3
            | (lock_loss_sticky & ~lock_loss_clear_reg); // RULE4
        irq_status_next = irq_status_reg;
        if (wr_en && addr == `SSPR_IRQ_STATUS_ADDR) begin
            irq_status_next = irq_status_reg & ~wr_data[1:0];
        end
        if (synth_unlocked) begin
            irq_status_next[`SSPR_IRQ_LOCK_BIT] = 1'b1;
        end
        if ((wr_en || rd_en) && !mapped) begin
            irq_status_next[`SSPR_IRQ_UNMAPPED_BIT] = 1'b1;
        end
    end

    // ====================================================
    // Pin function mapping
    // Value 0x00 means unused, so index 0 as a control input is not reachable
    always @* begin
        ctrl_table_next = 128'h0;
        ctrl_mask_next = 128'h0;
        pin_out_next = 2'b00;
        pin_oe_next = 2'b00;
        func = 8'h00;
        for (p = 0; p < 2; p = p + 1) begin
            func = (p == 0) ? pin0_func_reg : pin1_func_reg;
            if (func[`SSPR_PIN_ROLE_BIT]) begin // RULE13
                pin_oe_next[p] = 1'b1;
                pin_out_next[p] = status_table[func[6:0]]; // RULE12
            end else if (func != `SSPR_BYTE_RESET) begin // RULE14
                ctrl_mask_next[func[6:0]] = 1'b1; // RULE12
                ctrl_table_next[func[6:0]] = pin_in[p]; // RULE13
            end
        end
    end

    // ====================================================
    // Register writes
    // Revision byte ignores writes so the value stays fixed
    always @(posedge mclk) begin
        if (reset) begin
            lock_loss_clear_reg <= 1'b0;
            phase_c_reg         <= `SSPR_PHASE_RESET;
            phase_d_reg         <= `SSPR_PHASE_RESET;
            osc_disable_reg     <= 1'b0;
            pin0_func_reg       <= `SSPR_BYTE_RESET; // RULE14
            pin1_func_reg       <= `SSPR_BYTE_RESET; // RULE14
            irq_mask_reg        <= 2'b00;
        end else if (ce && wr_en) begin
            case (addr)
                `SSPR_LOCK_CLEAR_ADDR: begin
                    lock_loss_clear_reg <= wr_data[0]; // RULE5
                end
                `SSPR_PHASE_C_LO_ADDR: begin
                    phase_c_reg[7:0] <= wr_data;
                end
                `SSPR_PHASE_C_HI_ADDR: begin
                    phase_c_reg[15:8] <= wr_data;
                end
                `SSPR_PHASE_D_LO_ADDR: begin
                    phase_d_reg[7:0] <= wr_data;
                end
                `SSPR_PHASE_D_HI_ADDR: begin
                    phase_d_reg[15:8] <= wr_data;
                end
                `SSPR_OSC_CTRL_ADDR: begin
                    osc_disable_reg <= wr_data[0]; // RULE10
                end
                `SSPR_PIN0_FUNC_ADDR: begin
                    pin0_func_reg <= wr_data;
                end
                `SSPR_PIN1_FUNC_ADDR: begin
                    pin1_func_reg <= wr_data;
                end
                `SSPR_IRQ_MASK_ADDR: begin
                    irq_mask_reg <= wr_data[1:0];
                end
                default: begin
                    irq_mask_reg <= irq_mask_reg;
                end
            endcase
        end
    end

    // ====================================================
    // Status flags and read data
    always @(posedge mclk) begin
        if (reset) begin
            lock_loss_sticky <= 1'b1; // RULE2
            irq_status_reg   <= 2'b00;
            rd_data          <= 8'h00;
        end else if (ce) begin
            lock_loss_sticky <= lock_loss_next; // RULE3
            irq_status_reg   <= irq_status_next;
            rd_data          <= rd_en ? rd_data_next : 8'h00;
        end
    end

    // ====================================================
    // Registered field outputs
    // One cycle behind the register, except irq which moves with irq_status_reg, so every output leaves a flop
    always @(posedge mclk) begin
        if (reset) begin
            period_shift_c      <= 13'h0000;
            eighth_turn_shift_c <= 3'h0;
            eighth_turn_steps_c <= 4'h0;
            period_shift_d      <= 13'h0000;
            eighth_turn_shift_d <= 3'h0;
            eighth_turn_steps_d <= 4'h0;
            osc_out_driver_en   <= 1'b1;
            ctrl_table          <= 128'h0;
            ctrl_pin_mask       <= 128'h0;
            pin_out             <= 2'b00;
            pin_oe              <= 2'b00;
            irq                 <= 1'b0;
        end else if (ce) begin
            period_shift_c      <= phase_c_reg[`SSPR_PERIOD_MSB:0]; // RULE6
            eighth_turn_shift_c <= phase_c_reg[15:`SSPR_TURN_LSB];
            eighth_turn_steps_c <= turn_steps(phase_c_reg[15:13]); // RULE7
            period_shift_d      <= phase_d_reg[`SSPR_PERIOD_MSB:0]; // RULE6
            eighth_turn_shift_d <= phase_d_reg[15:`SSPR_TURN_LSB];
            eighth_turn_steps_d <= turn_steps(phase_d_reg[15:13]); // RULE8
            osc_out_driver_en   <= ~osc_disable_reg; // RULE9
            ctrl_table          <= ctrl_table_next;
            ctrl_pin_mask       <= ctrl_mask_next;
            pin_out             <= pin_out_next;
            pin_oe              <= pin_oe_next;
            irq                 <= |(irq_status_next & irq_mask_reg);
        end
    end

endmodule // sspr_regs

// *** logic/sspr_defs.vh ***
/*
 * Register map, field positions, reset values and event bits
 * of the synthesizer status, phase shift and pin function slice.
 * Assumes byte-wide registers on an 8-bit address port.
 */
// Overview of operation
// [RULE1] Bit 0 of the lock-loss status register reads high while lock has been lost.
// [RULE2] The lock-loss flag comes up set after every reset.
// [RULE3] The flag is sticky until cleared, so a flag seen set after a clear means a new loss.
// [RULE4] While bit 0 of the clear register is high the flag is held clear; the code still sets it in any cycle with ce and synth_unlocked high.
// [RULE5] Software writes the clear bit low again so new losses are recorded.
// [RULE6] A 13-bit two's complement field per divider C and D shifts by whole periods.
// [RULE7] A 3-bit field per divider adds a shift in 45 degree steps with a fixed encoding.
// [RULE8] Divider D uses exactly the divider C encoding, 011 meaning -135 degrees.
// [RULE9] Oscillator register bit 0 low enables the oscillator driver, high disables it.
// [RULE10] Software sets that bit for an external oscillator and clears it for a crystal.
// [RULE11] The revision register returns a fixed 8-bit revision value.
// [RULE12] Each pin function register holds a 7-bit index into a 128-bit table.
// [RULE13] Bit 7 low makes the pin an input to a control bit, high an output of a status bit.
// [RULE14] Both pin function registers reset to zero, leaving the pins unused.
// [RULE15] Software writes reserved bits only with their default values.
`ifndef SSPR_DEFS_VH
`define SSPR_DEFS_VH

// ====================================================
// Register offsets
`define SSPR_LOCK_STATUS_ADDR  8'hB9
`define SSPR_LOCK_CLEAR_ADDR   8'hBA
`define SSPR_PHASE_C_LO_ADDR   8'hBF
`define SSPR_PHASE_C_HI_ADDR   8'hC0
`define SSPR_PHASE_D_LO_ADDR   8'hC1
`define SSPR_PHASE_D_HI_ADDR   8'hC2
`define SSPR_OSC_CTRL_ADDR     8'hC3
`define SSPR_REVISION_ADDR     8'hC6
`define SSPR_PIN0_FUNC_ADDR    8'hE0
`define SSPR_PIN1_FUNC_ADDR    8'hE1
`define SSPR_IRQ_STATUS_ADDR   8'hF0
`define SSPR_IRQ_MASK_ADDR     8'hF1

// ====================================================
// Fields and reset values
`define SSPR_PERIOD_MSB        12
`define SSPR_TURN_LSB          13
`define SSPR_PIN_ROLE_BIT      7
`define SSPR_PHASE_RESET       16'h0000
`define SSPR_BYTE_RESET        8'h00
// Arbitrary revision value, not a real part code
`define SSPR_REVISION_VALUE    8'h5A
`define SSPR_IRQ_LOCK_BIT      0
`define SSPR_IRQ_UNMAPPED_BIT  1

`endif

// *** tb/sspr_regs_sva.sv ***
/* Port checker for the register slice.
   Assumes sspr_regs on one clock, bound from the tb top file. */
`timescale 1ns/100ps
`include "sspr_defs.vh"
module sspr_regs_sva (
    input wire         mclk,
    input wire         reset,
    input wire         ce,
    input wire [7:0]   addr,
    input wire [7:0]   wr_data,
    input wire         wr_en,
    input wire         rd_en,
    input wire [7:0]   rd_data,
    input wire         synth_unlocked,
    input wire         lock_loss_sticky,
    input wire         osc_out_driver_en,
    input wire [1:0]   pin_oe,
    input wire [127:0] ctrl_pin_mask
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // ====================
    // Shadow of the clear bit, so stickiness is judged without the body
    reg clr_reg;
    always @(posedge mclk) begin
        if (reset)
            clr_reg <= 1'b0;
        else if (ce && wr_en && addr == `SSPR_LOCK_CLEAR_ADDR)
            clr_reg <= wr_data[0];
    end
    sequence s_osc_wr;
        ce && wr_en && addr == `SSPR_OSC_CTRL_ADDR ##1 ce;
    endsequence
    sequence s_pin0_stat;
        ce && wr_en && addr == `SSPR_PIN0_FUNC_ADDR && wr_data[7] ##1 ce;
    endsequence
    // ====================
    // Properties
    a_lock_set: assert property (ce && synth_unlocked |=> lock_loss_sticky)
        else $error("lock flag missed a loss");
    a_lock_reset: assert property ($fell(reset) |-> lock_loss_sticky)
        else $error("lock flag clear after reset");
    a_lock_sticky: assert property (ce && lock_loss_sticky && !clr_reg |=> lock_loss_sticky)
        else $error("lock flag dropped on its own");
    a_lock_clear: assert property (ce && clr_reg && !synth_unlocked |=> !lock_loss_sticky)
        else $error("lock flag not cleared");
    a_read_status: assert property (ce && rd_en && addr == `SSPR_LOCK_STATUS_ADDR
        |=> rd_data == {7'h00, $past(lock_loss_sticky)})
        else $error("status read wrong");
    a_rev_read: assert property (ce && rd_en && addr == `SSPR_REVISION_ADDR
        |=> rd_data == `SSPR_REVISION_VALUE)
        else $error("revision read wrong");
    a_read_idle: assert property (ce && !rd_en |=> rd_data == 8'h00)
        else $error("read data outside its cycle");
    a_osc_follow: assert property (s_osc_wr |=> osc_out_driver_en == ~$past(wr_data[0], 2))
        else $error("oscillator driver wrong");
    a_pin_role: assert property (s_pin0_stat |=> pin_oe[0])
        else $error("status pin not driven");
    a_pin_reset: assert property ($fell(reset) |-> pin_oe == 2'h0 && ctrl_pin_mask == 128'h0)
        else $error("pins in use after reset");
    a_ce_hold: assert property (!ce |=> $stable(lock_loss_sticky) && $stable(rd_data)
        && $stable(osc_out_driver_en))
        else $error("state moved while clock enable low");
endmodule // sspr_regs_sva

// *** tb/tb.sv ***
/* Self-checking bench for the register slice.
   Assumes sspr_regs with a one-cycle strobe bus on mclk. */
`timescale 1ns/100ps
`include "sspr_defs.vh"
module tb;
    reg          mclk, reset, ce, wr_en, rd_en, synth_unlocked;
    reg  [7:0]   addr, wr_data, d;
    reg  [127:0] status_table;
    reg  [1:0]   pin_in;
    wire [7:0]   rd_data;
    wire         lock_loss_sticky, osc_out_driver_en, irq;
    wire [12:0]  period_shift_c, period_shift_d;
    wire [2:0]   eighth_turn_shift_c, eighth_turn_shift_d;
    wire [3:0]   eighth_turn_steps_c, eighth_turn_steps_d;
    wire [127:0] ctrl_table, ctrl_pin_mask;
    wire [1:0]   pin_out, pin_oe;
    integer      fail_count, n_tests, k;
    reg  [3:0]   e;
    sspr_regs sspr_regs_inst (.mclk, .reset, .ce, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .synth_unlocked, .status_table, .pin_in, .lock_loss_sticky,
        .period_shift_c, .eighth_turn_shift_c, .eighth_turn_steps_c, .period_shift_d,
        .eighth_turn_shift_d, .eighth_turn_steps_d, .osc_out_driver_en, .ctrl_table,
        .ctrl_pin_mask, .pin_out, .pin_oe, .irq);
    // ====================
    // Bus and helper tasks
    task check(input logic [127:0] got, input logic [127:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge mclk);
            addr <= a; wr_data <= v; wr_en <= 1'b1;
            @(posedge mclk);
            wr_en <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge mclk);
            addr <= a; rd_en <= 1'b1;
            @(posedge mclk);
            rd_en <= 1'b0;
            #1 d = rd_data;
        end
    endtask
    task settle;
        begin
            @(posedge mclk);
            #1;
        end
    endtask
    task pulse;
        begin
            @(posedge mclk);
            synth_unlocked <= 1'b1;
            @(posedge mclk);
            synth_unlocked <= 1'b0;
            settle;
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // ====================
    // Scenarios
    task t_reset;
        begin
            rd(`SSPR_LOCK_STATUS_ADDR); check(d, 8'h01);
            rd(`SSPR_REVISION_ADDR); check(d, `SSPR_REVISION_VALUE);
            rd(`SSPR_PIN0_FUNC_ADDR); check(d, 8'h00);
            rd(`SSPR_PIN1_FUNC_ADDR); check(d, 8'h00);
            check(pin_oe, 2'h0);
        end
    endtask
    task t_lock;
        begin
            wr(`SSPR_LOCK_CLEAR_ADDR, 8'h01); settle;
            check(lock_loss_sticky, 1'b0);
            wr(`SSPR_LOCK_CLEAR_ADDR, 8'h00);
            pulse; settle;
            check(lock_loss_sticky, 1'b1);
            rd(`SSPR_LOCK_STATUS_ADDR); check(d, 8'h01);
        end
    endtask
    task t_phase;
        begin
            wr(`SSPR_PHASE_C_LO_ADDR, 8'hFF); wr(`SSPR_PHASE_D_LO_ADDR, 8'h01);
            for (k = 0; k < 8; k = k + 1) begin
                wr(`SSPR_PHASE_C_HI_ADDR, (k << 5) | 8'h1F);
                wr(`SSPR_PHASE_D_HI_ADDR, k << 5); settle;
                e = (k < 4) ? 4'h0 - k[3:0] : 4'h8 - k[3:0];
                check(period_shift_c, 13'h1FFF);
                check(period_shift_d, 13'h0001);
                check(eighth_turn_shift_c, k);
                check(eighth_turn_shift_d, k);
                check(eighth_turn_steps_c, e);
                check(eighth_turn_steps_d, e);
            end
        end
    endtask
    task t_osc_pins;
        begin
            check(osc_out_driver_en, 1'b1);
            wr(`SSPR_OSC_CTRL_ADDR, 8'h01); settle;
            check(osc_out_driver_en, 1'b0);
            ce <= 1'b0;
            wr(`SSPR_OSC_CTRL_ADDR, 8'h00); settle;
            check(osc_out_driver_en, 1'b0);
            ce <= 1'b1;
            settle;
            status_table <= 128'h20;
            wr(`SSPR_PIN0_FUNC_ADDR, 8'h85); settle;
            check(pin_oe[0], 1'b1); check(pin_out[0], 1'b1);
            status_table <= 128'h0; settle;
            check(pin_out[0], 1'b0);
            pin_in <= 2'h2;
            wr(`SSPR_PIN1_FUNC_ADDR, 8'h03); settle;
            check(ctrl_pin_mask[3], 1'b1); check(ctrl_table[3], 1'b1);
            check(pin_oe[1], 1'b0);
        end
    endtask
    task t_irq;
        begin
            pulse; check(irq, 1'b0);
            wr(`SSPR_IRQ_MASK_ADDR, 8'h03); settle; check(irq, 1'b1);
            wr(`SSPR_IRQ_STATUS_ADDR, 8'h01); settle; check(irq, 1'b0);
            rd(8'h10); check(d, 8'h00);
            settle; check(irq, 1'b1);
            wr(`SSPR_IRQ_STATUS_ADDR, 8'h02); settle; check(irq, 1'b0);
        end
    endtask
    // ====================
    // Clock, watchdog, main sequence
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count = fail_count + 1;
        close_out;
    end
    initial begin
        fail_count = 0; n_tests = 0; reset = 1'b1; ce = 1'b1; wr_en = 1'b0;
        rd_en = 1'b0; addr = 8'h00; wr_data = 8'h00; synth_unlocked = 1'b0;
        status_table = 128'h0; pin_in = 2'h0; d = 8'h00;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_reset; t_lock; t_phase; t_osc_pins; t_irq;
        close_out;
    end
endmodule // tb
bind sspr_regs sspr_regs_sva sspr_regs_sva_inst (.mclk, .reset, .ce, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data, .synth_unlocked, .lock_loss_sticky, .osc_out_driver_en,
    .pin_oe, .ctrl_pin_mask);
